// file: inc/ugtp_map.vh
// Register map and constants for the guard-time and prescaler block.
// Assumes inclusion by bare name from the design file.
`ifndef UGTP_MAP_VH
`define UGTP_MAP_VH
`define UGTP_OFF_GTPSC   12'h018
`define UGTP_OFF_MODE    12'h01c
`define UGTP_OFF_STATUS  12'h020
`define UGTP_OFF_MASK    12'h024
`define UGTP_RST_GTPSC   16'h0000
`define UGTP_RST_MODE    3'h0
`define UGTP_RST_MASK    2'h0
`define UGTP_DIV_LSB     0
`define UGTP_DIV_MSB     7
`define UGTP_GRD_LSB     8
`define UGTP_GRD_MSB     15
`define UGTP_MODE_INFRARED_ENABLE   0
`define UGTP_MODE_IRLP   1
`define UGTP_MODE_SMARTCARD_ENABLE   2
`define UGTP_ST_TXDONE   0
`define UGTP_ST_BADDIV   1
`endif

// file: rtl/ugtp_guard_prescaler.v
// Guard-time and prescaler block of a serial transceiver, APB slave.
// Assumes a single clock, a baud tick and frame-end pulse from the transmitter core.
// Functional notes
// - Low-power infrared divides by full eight bits.
// - Smartcard divides by twice low five bits.
// - Smartcard delays tx done by guard baud periods.
// - Reduced instances lack divider and guard fields.
// - Low-power select chooses infrared low-power operation.
// - Smartcard divider and guard only when enabled.
// - Infrared enable bit turns infrared function on.
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "ugtp_map.vh"

module ugtp_guard_prescaler #(
	parameter FULL_FEATURES = 1
) (
	input  wire        clock,
	input  wire        rst_b,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire        baudTick,
	input  wire        frameEnd,
	output wire        prescaledClk,
	output wire        infraredActive,
	output wire        infraredLowPower,
	output wire        smartcardActive,
	output wire        txDoneFlag,
	output wire        irq
);

	////////////////////////////////////////////////////////////////////
	// Register file
	// Four word registers on the bus, all answered with zero wait states.
	// Read data is captured in the setup cycle, so the access phase only
	// presents a value that already stands in a flip-flop.
	// Unmapped offsets answer with an error and read as zero; writes to
	// them are dropped.
	// Upper sixteen bits of the guard/divider word are reserved and read
	// back as zero.

	reg  [15:0] gtpsc_ff;
	reg  [2:0]  mode_ff;
	reg  [1:0]  status_ff;
	reg  [1:0]  mask_ff;
	wire        acc   = psel & penable;
	wire        wrAcc = acc & pwrite;
	wire        rdAcc = acc & ~pwrite;
	wire        hitG  = (paddr == `UGTP_OFF_GTPSC);
	wire        hitM  = (paddr == `UGTP_OFF_MODE);
	wire        hitS  = (paddr == `UGTP_OFF_STATUS);
	wire        hitK  = (paddr == `UGTP_OFF_MASK);

	assign pready  = 1'b1;
	assign pslverr = acc & ~(hitG | hitM | hitS | hitK);

	wire [7:0] divVal   = gtpsc_ff[`UGTP_DIV_MSB:`UGTP_DIV_LSB];
	wire [7:0] guardVal = gtpsc_ff[`UGTP_GRD_MSB:`UGTP_GRD_LSB];

	assign infraredActive   = mode_ff[`UGTP_MODE_INFRARED_ENABLE];
	assign infraredLowPower = mode_ff[`UGTP_MODE_INFRARED_ENABLE] & mode_ff[`UGTP_MODE_IRLP];
	assign smartcardActive  = mode_ff[`UGTP_MODE_SMARTCARD_ENABLE];

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			gtpsc_ff <= `UGTP_RST_GTPSC;
			mode_ff  <= `UGTP_RST_MODE;
			mask_ff  <= `UGTP_RST_MASK;
		end else if (wrAcc) begin
			// Fields stay zero on reduced instances
			if (hitG && FULL_FEATURES != 0)
				gtpsc_ff <= pwdata[15:0];
			if (hitM)
				mode_ff <= pwdata[2:0];
			if (hitK)
				mask_ff <= pwdata[1:0];
		end
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0000_0000;
			if (hitG)
				prdata <= {16'h0000, gtpsc_ff};
			if (hitM)
				prdata <= {29'h0000_0000, mode_ff};
			if (hitS)
				prdata <= {30'h0000_0000, status_ff};
			if (hitK)
				prdata <= {30'h0000_0000, mask_ff};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Prescaler: half period count in smartcard, full period count in low-power infrared; smartcard uses low five bits
	// Smartcard wins over infrared when both are enabled, so the wider
	// infrared divider never leaks into a smartcard clock.
	// A divider of one in low-power infrared keeps the output high, which
	// stands for the undivided source clock.
	// Changing the divider mid-period lets the current count run out
	// against the new limit; no glitch-free handover is attempted.

	reg  [7:0] preCnt_ff;
	reg        preClk_ff;
	wire       divRun = (FULL_FEATURES != 0) &
	                    (smartcardActive | infraredLowPower);
	// Smartcard: toggle every CLOCK_DIVIDER_VALUE[4:0] cycles gives divide by 2x
	// Low-power IR: output a one-cycle pulse every CLOCK_DIVIDER_VALUE cycles
	wire [7:0] period = smartcardActive ? {3'h0, divVal[4:0]} : divVal;
	wire       badDiv = divRun & (period == 8'h00);
	wire       wrap   = (preCnt_ff + 8'h01 >= period);

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			preCnt_ff <= 8'h00;
			preClk_ff <= 1'b0;
		end else if (!divRun || badDiv) begin
			// Zero divider is reserved: clock held still
			preCnt_ff <= 8'h00;
			preClk_ff <= 1'b0;
		end else if (wrap) begin
			preCnt_ff <= 8'h00;
			preClk_ff <= smartcardActive ? ~preClk_ff : 1'b1;
		end else begin
			preCnt_ff <= preCnt_ff + 8'h01;
			preClk_ff <= smartcardActive ? preClk_ff : 1'b0;
		end
	end
	assign prescaledClk = preClk_ff;

	////////////////////////////////////////////////////////////////////
	// Guard interval before tx done
	// The counter is loaded at frame end and steps on baud ticks only, so
	// the wait is a whole number of baud periods after the frame.
	// A frame end that arrives while waiting is ignored for the guard; the
	// transmitter core is not expected to send during the guard interval.
	// The flag itself is a level, dropped by a frame end unless that frame end needs no guard and sets it again.

	localparam G_IDLE = 1'b0;
	localparam G_WAIT = 1'b1;
	reg       gState_ff;
	reg [7:0] gCnt_ff;
	reg       txDone_ff;
	wire      useGuard = smartcardActive & (FULL_FEATURES != 0);
	reg       doneEvt;

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			gState_ff <= G_IDLE;
			gCnt_ff   <= 8'h00;
		end else begin
			case (gState_ff)
			G_IDLE: begin
				if (frameEnd && useGuard && guardVal != 8'h00) begin
					gState_ff <= G_WAIT;
					gCnt_ff   <= guardVal;
				end
			end
			G_WAIT: begin
				if (baudTick && gCnt_ff == 8'h01)
					gState_ff <= G_IDLE;
				if (baudTick)
					gCnt_ff <= gCnt_ff - 8'h01;
			end
			default: gState_ff <= G_IDLE;
			endcase
		end
	end

	always @* begin
		doneEvt = 1'b0;
		if (gState_ff == G_IDLE && frameEnd && (!useGuard || guardVal == 8'h00))
			doneEvt = 1'b1;
		if (gState_ff == G_WAIT && baudTick && gCnt_ff == 8'h01)
			doneEvt = 1'b1;
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			txDone_ff <= 1'b0;
		else if (doneEvt)
			txDone_ff <= 1'b1;
		else if (frameEnd)
			txDone_ff <= 1'b0;
	end
	assign txDoneFlag = txDone_ff;

	////////////////////////////////////////////////////////////////////
	// Sticky status, cleared by reading; a new event wins over the clear
	// Only the bits captured in the setup cycle are cleared: an event that
	// lands between setup and access would otherwise be lost unseen.
	// The interrupt is a plain level so software can poll or take it.

	wire       rdStat = rdAcc & hitS;
	wire [1:0] clrBits = rdStat ? prdata[1:0] : 2'h0;

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			status_ff <= 2'h0;
		else
			status_ff <= (status_ff & ~clrBits) | {badDiv, doneEvt};
	end

	assign irq = |(status_ff & mask_ff);

endmodule // ugtp_guard_prescaler
`default_nettype wire

// file: test/testbench.sv
// APB call sequences with expected values for the guard-time block.
// Assumes the line model supplies baud ticks and frame ends.
`timescale 1ns/100ps
`default_nettype none
`include "ugtp_map.vh"
module testbench;
logic        clock = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
logic        sendFrame = 1'h0;
logic [11:0] paddr = 12'h0;
logic [31:0] pwdata = 32'h0;
wire  [31:0] prdata, prdataRed;
wire         pready, pslverr, baudTick, frameEnd, prescaledClk, irq, txDoneFlag;
wire         infraredActive, infraredLowPower, smartcardActive;
int          errors = 0, total_checks = 0, n, t;
ugtp_guard_prescaler u_dut (
	.clock            (clock),
	.rst_b            (rst_b),
	.psel             (psel),
	.penable          (penable),
	.pwrite           (pwrite),
	.paddr            (paddr),
	.pwdata           (pwdata),
	.pready           (pready),
	.prdata           (prdata),
	.pslverr          (pslverr),
	.baudTick         (baudTick),
	.frameEnd         (frameEnd),
	.prescaledClk     (prescaledClk),
	.infraredActive   (infraredActive),
	.infraredLowPower (infraredLowPower),
	.smartcardActive  (smartcardActive),
	.txDoneFlag       (txDoneFlag),
	.irq              (irq)
);
// Reduced instance shares the bus; only its read data is watched
ugtp_guard_prescaler #(.FULL_FEATURES(0)) u_dutReduced (
	.clock            (clock),
	.rst_b            (rst_b),
	.psel             (psel),
	.penable          (penable),
	.pwrite           (pwrite),
	.paddr            (paddr),
	.pwdata           (pwdata),
	.pready           (),
	.prdata           (prdataRed),
	.pslverr          (),
	.baudTick         (baudTick),
	.frameEnd         (frameEnd),
	.prescaledClk     (),
	.infraredActive   (),
	.infraredLowPower (),
	.smartcardActive  (),
	.txDoneFlag       (),
	.irq              ()
);
ugtp_line_model u_line (
	.clock     (clock),
	.rst_b     (rst_b),
	.sendFrame (sendFrame),
	.baudTick  (baudTick),
	.frameEnd  (frameEnd)
);
initial forever #50 clock = ~clock;
initial begin
	repeat (20000) @(posedge clock);
	errors++;
	give_verdict;
end
task chk(input logic [32:0] s, e);
	total_checks++;
	if (s !== e) begin
		errors++;
		$display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
	end
endtask
task give_verdict;
	$display("checks %0d mismatches %0d", total_checks, errors);
	if (errors == 0 && total_checks > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
endtask
task ap(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
	@(posedge clock);
	{psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
	@(posedge clock);
	penable <= 1'h1;
	@(posedge clock);
	while (pready !== 1'h1) @(posedge clock);
	if (!w) chk({pslverr, prdata}, e);
	{psel, penable} <= 2'h0;
endtask
task tk;
	@(posedge clock);
	#1;
	n++;
endtask
// Second pass times one full period from a rising edge
task per(input logic [32:0] e);
	repeat (2) begin
		n = 0;
		while (prescaledClk === 1'h1 && n < 300) tk;
		while (prescaledClk !== 1'h1 && n < 300) tk;
	end
	chk(33'(n), e);
endtask
task frm(input logic [32:0] e);
	n = 0;
	t = 0;
	@(posedge clock);
	sendFrame <= 1'h1;
	@(posedge clock);
	sendFrame <= 1'h0;
	tk;
	while (txDoneFlag !== 1'h1 && n < 300) begin
		t += baudTick;
		tk;
	end
	chk(33'(t), e);
endtask
initial begin
	repeat (6) @(posedge clock);
	rst_b <= 1'h1;
	ap(1'h0, `UGTP_OFF_GTPSC, 32'h0, 33'h0);
	ap(1'h0, 12'h030, 32'h0, 33'h1_0000_0000);
	ap(1'h1, `UGTP_OFF_MODE, 32'h4, 33'h0);
	ap(1'h1, `UGTP_OFF_GTPSC, 32'hffff_00ff, 33'h0);
	ap(1'h0, `UGTP_OFF_GTPSC, 32'h0, 33'hff);
	chk({1'h0, prdataRed}, 33'h0);
	ap(1'h0, `UGTP_OFF_STATUS, 32'h0, 33'h2);
	per(33'h3e);
	frm(33'h0);
	$display("smartcard divider done");
	ap(1'h1, `UGTP_OFF_MASK, 32'h1, 33'h0);
	ap(1'h1, `UGTP_OFF_GTPSC, 32'h3ff, 33'h0);
	frm(33'h3);
	chk({32'h0, irq}, 33'h1);
	ap(1'h0, `UGTP_OFF_STATUS, 32'h0, 33'h1);
	@(posedge clock);
	chk({32'h0, irq}, 33'h0);
	$display("guard done");
	ap(1'h1, `UGTP_OFF_MODE, 32'h3, 33'h0);
	ap(1'h1, `UGTP_OFF_GTPSC, 32'h7, 33'h0);
	per(33'h7);
	ap(1'h1, `UGTP_OFF_GTPSC, 32'h501, 33'h0);
	ap(1'h1, `UGTP_OFF_MODE, 32'h1, 33'h0);
	frm(33'h0);
	chk({30'h0, infraredActive, infraredLowPower, smartcardActive}, 33'h4);
	$display("infrared done");
	give_verdict;
end
endmodule // testbench
bind ugtp_guard_prescaler ugtp_properties u_props (
	.clock            (clock),
	.rst_b            (rst_b),
	.psel             (psel),
	.penable          (penable),
	.pwrite           (pwrite),
	.pready           (pready),
	.pslverr          (pslverr),
	.baudTick         (baudTick),
	.frameEnd         (frameEnd),
	.txDoneFlag       (txDoneFlag),
	.irq              (irq),
	.smartcardActive  (smartcardActive),
	.infraredLowPower (infraredLowPower),
	.prescaledClk     (prescaledClk),
	.prdata           (prdata)
);
`default_nettype wire

// file: test/ugtp_line_model.sv
// Transmitter-core stand-in: baud ticks and frame-end pulses.
// Assumes the bench pulses sendFrame for one clock per frame.
`timescale 1ns/100ps
`default_nettype none
module ugtp_line_model (
	input  wire logic clock, rst_b, sendFrame,
	output var  logic baudTick, frameEnd
);
logic [1:0] baudCnt_ff;
// Four clocks per baud keeps guard waits short
always @(posedge clock or negedge rst_b)
	if (!rst_b) {baudTick, frameEnd, baudCnt_ff} <= 4'h0;
	else {baudTick, frameEnd, baudCnt_ff} <= {baudCnt_ff == 2'h3, sendFrame, baudCnt_ff + 2'h1};
endmodule // ugtp_line_model
`default_nettype wire

// file: test/ugtp_properties.sv
// Port assertions for the guard-time and prescaler block.
// Assumes a bind onto ugtp_guard_prescaler with one clock domain.
`timescale 1ns/100ps
`default_nettype none
module ugtp_properties (
	input wire logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, baudTick,
	input wire logic        frameEnd, txDoneFlag, irq, smartcardActive, infraredLowPower,
	input wire logic        prescaledClk,
	input wire logic [31:0] prdata
);
default clocking @(posedge clock); endclocking
default disable iff (!rst_b);
property p_rdy; pready; endproperty
a_rdy: assert property (p_rdy) else $error("no ready");
property p_err; pslverr |-> psel && penable; endproperty
a_err: assert property (p_err) else $error("stray slverr");
property p_rd; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
a_rd: assert property (p_rd) else $error("read data moved");
// Done may lag its cause by one extra edge
property p_set; $rose(txDoneFlag) |-> $past(frameEnd || baudTick, 2) || $past(frameEnd || baudTick); endproperty
a_set: assert property (p_set) else $error("done without cause");
property p_keep; txDoneFlag && !frameEnd |=> txDoneFlag; endproperty
a_keep: assert property (p_keep) else $error("done dropped");
property p_clr; $fell(txDoneFlag) |-> $past(frameEnd); endproperty
a_clr: assert property (p_clr) else $error("done cleared early");
property p_off; !(smartcardActive || infraredLowPower) [*2] |-> !prescaledClk; endproperty
a_off: assert property (p_off) else $error("divided clock outside modes");
property p_irq; $fell(irq) |-> $past(psel && penable); endproperty
a_irq: assert property (p_irq) else $error("irq dropped");
endmodule // ugtp_properties
`default_nettype wire
